// File: src/sbsa_defs.svh
/*
 * constants of the synchronous burst sram access block: lane layout,
 * default address width and burst counter values.
 * assumes: included by its bare name from the package and the modules.
 */
`ifndef SBSA_DEFS_SVH
`define SBSA_DEFS_SVH

// lane layout
`define SBSA_LANE_BITS  8
`define SBSA_PAR_BITS   1
`define SBSA_LANES      4

// default word address width
`define SBSA_ADDR_W     19

// burst counter
`define SBSA_BURST_W    2
`define SBSA_BURST_ZERO 2'h0
`define SBSA_BURST_ONE  2'h1

`endif

// File: src/sbsa_mem.sv
/*
 * flip-flop storage array with per-lane write enables and an
 * asynchronous read port.
 * assumes: word layout is {parity lanes, data lanes}, lane l owns data
 * bits [l*8 +: 8] and parity bit [data width + l].
 */
`timescale 1ns/1ps
`default_nettype none
`include "sbsa_defs.svh"

module sbsa_mem #(
  parameter int ADDR_W = `SBSA_ADDR_W,
  parameter int LANES  = `SBSA_LANES
) (
  input  wire logic                                        i_core_clk,
  input  wire logic [LANES-1:0]                            i_we,
  input  wire logic [ADDR_W-1:0]                           i_waddr,
  input  wire logic [LANES*(`SBSA_LANE_BITS+1)-1:0]        i_wdata,
  input  wire logic [ADDR_W-1:0]                           i_raddr,
  output logic      [LANES*(`SBSA_LANE_BITS+1)-1:0]        o_rdata
);

  localparam int DATA_W = LANES * `SBSA_LANE_BITS;
  localparam int WORD_W = LANES * (`SBSA_LANE_BITS + `SBSA_PAR_BITS);

  logic [WORD_W-1:0] store [2**ADDR_W];

  // each lane writes its data byte together with its parity bit
  always_ff @(posedge i_core_clk) begin
    for (int l = 0; l < LANES; l++) begin
      if (i_we[l]) begin
        store[i_waddr][l*`SBSA_LANE_BITS +: `SBSA_LANE_BITS] <=
          i_wdata[l*`SBSA_LANE_BITS +: `SBSA_LANE_BITS];
        store[i_waddr][DATA_W+l] <= i_wdata[DATA_W+l];
      end
    end
  end

  // read port feeds the output register inputs
  assign o_rdata = store[i_raddr];

endmodule
`default_nettype wire

// File: src/sbsa_pkg.sv
/*
 * types shared by the synchronous burst sram access block.
 * assumes: nothing beyond the constants header.
 */
`include "sbsa_defs.svh"

package sbsa_pkg;

  // synchronous control inputs of the bus, all active levels as on the pins
  typedef struct packed {
    logic cs1_n;     // chip_select_1_n
    logic cs2;       // chip_select_2
    logic cs3_n;     // chip_select_3_n
    logic processor_addr_strobe_n_n;    // processor_addr_strobe_n
    logic controller_addr_strobe_n_n;    // controller_addr_strobe_n
    logic adv_n;     // burst_advance_n
    logic gw_n;      // global_write_n
    logic bwe_n;     // byte_write_enable_n
  } sbsa_ctrl_t;

  // access state
  typedef enum logic [1:0] {
    SBSA_IDLE,
    SBSA_ACTIVE,
    SBSA_SLEEP
  } sbsa_state_t;

endpackage

// File: src/sbsa_top.sv
/*
 * synchronous pipelined burst sram access logic: strobes, chip selects,
 * two-bit burst counter, byte/global writes, registered read data and
 * output drive control, sleep.
 * assumes: all bus inputs are synchronous to i_core_clk except
 * drive_enable_n, sleep_request and the burst order strap, which are
 * synchronised here; the bench resolves the shared lanes from o_lane_oe.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sbsa_defs.svh"

module sbsa_top #(
  parameter int ADDR_W = `SBSA_ADDR_W,
  parameter int LANES  = `SBSA_LANES
) (
  input  wire logic                              i_core_clk,
  input  wire logic                              i_rst_n,
  input  wire logic [ADDR_W-1:0]                 i_addr,
  input  wire sbsa_pkg::sbsa_ctrl_t              i_ctrl,
  input  wire logic [LANES-1:0]                  i_lane_write_select_n,
  input  wire logic                              i_drive_enable_n,
  input  wire logic                              i_sleep_request,
  input  wire logic                              i_burst_order_strap,
  input  wire logic [LANES*`SBSA_LANE_BITS-1:0]  i_data_lane,
  input  wire logic [LANES-1:0]                  i_parity_lane,
  output logic      [LANES*`SBSA_LANE_BITS-1:0]  o_data_lane,
  output logic      [LANES-1:0]                  o_parity_lane,
  output logic                                   o_lane_oe,
  output logic                                   o_asleep
);

  localparam int DATA_W = LANES * `SBSA_LANE_BITS;
  localparam int WORD_W = LANES * (`SBSA_LANE_BITS + `SBSA_PAR_BITS);

  // refuse shapes the logic cannot serve
  if (ADDR_W < `SBSA_BURST_W) begin : g_chk_addr
    $error("ADDR_W must cover the burst counter bits");
  end
  if (LANES < 1) begin : g_chk_lanes
    $error("LANES must be at least one");
  end

  ////////////////////////////////////////////////////////////////////////
  // functions

  // burst address bits for a start value and a step count
  function automatic logic [`SBSA_BURST_W-1:0] burst_bits(
    input logic [`SBSA_BURST_W-1:0] start_v,
    input logic [`SBSA_BURST_W-1:0] steps,
    input logic                     interleave
  );
    burst_bits = interleave ? (start_v ^ steps) : (start_v + steps);
  endfunction

  // lanes that the write controls ask to write
  function automatic logic [LANES-1:0] write_lanes(
    input logic             gw_n,
    input logic             bwe_n,
    input logic [LANES-1:0] sel_n
  );
    if (!gw_n) begin
      write_lanes = '1;
    end else if (!bwe_n) begin
      write_lanes = ~sel_n;
    end else begin
      write_lanes = '0;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // synchronisers for the asynchronous inputs

  logic sleep_m;
  logic sleep_s;
  logic oe_n_m;
  logic oe_n_s;
  logic strap_m;
  logic strap_s;

  // two flops each; undriven and interleaved after reset
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      sleep_m <= 1'b0;
      sleep_s <= 1'b0;
      oe_n_m  <= 1'b1;
      oe_n_s  <= 1'b1;
      strap_m <= 1'b1;
      strap_s <= 1'b1;
    end else begin
      sleep_m <= i_sleep_request;
      sleep_s <= sleep_m;
      oe_n_m  <= i_drive_enable_n;
      oe_n_s  <= oe_n_m;
      strap_m <= i_burst_order_strap;
      strap_s <= strap_m;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // access decode

  sbsa_pkg::sbsa_state_t st;
  sbsa_pkg::sbsa_state_t next_st;
  logic [ADDR_W-1:0]        cur_addr;
  logic [`SBSA_BURST_W-1:0] start_bits;
  logic [`SBSA_BURST_W-1:0] burst_cnt;
  logic                     p_first;
  logic                     rd_pend;

  logic                     awake;
  logic                     sel;
  logic                     p_strobe;
  logic                     c_strobe;
  logic                     start;
  logic                     cont;
  logic                     adv_step;
  logic [LANES-1:0]         lane_req;
  logic                     wr_req;
  logic [`SBSA_BURST_W-1:0] next_cnt;
  logic [ADDR_W-1:0]        acc_addr;
  logic [LANES-1:0]         mem_we;
  logic                     rd_go;
  logic [WORD_W-1:0]        mem_rdata;

  // strobe qualification and select
  assign awake    = (st != sbsa_pkg::SBSA_SLEEP) && !sleep_s;
  assign sel      = !i_ctrl.cs1_n && i_ctrl.cs2 && !i_ctrl.cs3_n;
  assign p_strobe = !i_ctrl.processor_addr_strobe_n_n && !i_ctrl.cs1_n;
  assign c_strobe = !i_ctrl.controller_addr_strobe_n_n && !p_strobe;
  assign start    = p_strobe || c_strobe;
  assign cont     = (st == sbsa_pkg::SBSA_ACTIVE) && !start;

  // burst stepping; advance is ignored in the cycle after a processor strobe
  assign adv_step = awake && cont && !i_ctrl.adv_n && !p_first;
  assign next_cnt = adv_step ? (burst_cnt + `SBSA_BURST_ONE) : burst_cnt;
  assign acc_addr = start ? i_addr
                  : {cur_addr[ADDR_W-1:`SBSA_BURST_W],
                     burst_bits(start_bits, next_cnt, strap_s)};

  // write lanes: controller strobe writes at once, processor strobe one later
  assign lane_req = write_lanes(i_ctrl.gw_n, i_ctrl.bwe_n, i_lane_write_select_n);
  assign wr_req   = |lane_req;
  always_comb begin
    mem_we = '0;
    if (awake && start && sel && c_strobe) begin
      mem_we = lane_req;
    end else if (awake && cont) begin
      mem_we = lane_req;
    end
  end

  // read begins: processor strobe always reads first, otherwise no write
  assign rd_go = awake && ((start && sel && (p_strobe || !wr_req))
                           || (cont && !wr_req));

  // lane data and parity are written from the bus at the edge
  sbsa_mem #(
    .ADDR_W (ADDR_W),
    .LANES  (LANES)
  ) u_mem (
    .i_core_clk (i_core_clk),
    .i_we       (mem_we),
    .i_waddr    (acc_addr),
    .i_wdata    ({i_parity_lane, i_data_lane}),
    .i_raddr    (cur_addr),
    .o_rdata    (mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // state

  // next state: sleep wins, a strobe selects or deselects
  always_comb begin
    next_st = st;
    case (st)
      sbsa_pkg::SBSA_SLEEP: begin
        if (!sleep_s) begin
          next_st = sbsa_pkg::SBSA_IDLE;
        end
      end
      sbsa_pkg::SBSA_IDLE,
      sbsa_pkg::SBSA_ACTIVE: begin
        if (sleep_s) begin
          next_st = sbsa_pkg::SBSA_SLEEP;
        end else if (start) begin
          next_st = sel ? sbsa_pkg::SBSA_ACTIVE : sbsa_pkg::SBSA_IDLE;
        end
      end
      default: begin
        next_st = sbsa_pkg::SBSA_IDLE;
      end
    endcase
  end

  // state and sleep status
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      st       <= sbsa_pkg::SBSA_IDLE;
      o_asleep <= 1'b0;
    end else begin
      st       <= next_st;
      o_asleep <= (next_st == sbsa_pkg::SBSA_SLEEP);
    end
  end

  // address register and burst counter
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      cur_addr   <= '0;
      start_bits <= `SBSA_BURST_ZERO;
      burst_cnt  <= `SBSA_BURST_ZERO;
      p_first    <= 1'b0;
    end else if (awake && start && sel) begin
      cur_addr   <= i_addr;
      start_bits <= i_addr[`SBSA_BURST_W-1:0];
      burst_cnt  <= `SBSA_BURST_ZERO;
      p_first    <= p_strobe;
    end else if (awake && cont) begin
      cur_addr   <= acc_addr;
      burst_cnt  <= next_cnt;
      p_first    <= 1'b0;
    end else begin
      p_first    <= 1'b0;
    end
  end

  // pending read marker; cleared when idle so a fresh select starts undriven
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      rd_pend <= 1'b0;
    end else begin
      rd_pend <= rd_go;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output registers and drive

  // data of the previous edge's address moves through the output register
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_data_lane   <= '0;
      o_parity_lane <= '0;
    end else if (rd_pend) begin
      o_data_lane   <= mem_rdata[DATA_W-1:0];
      o_parity_lane <= mem_rdata[WORD_W-1:DATA_W];
    end
  end

  // drive only a read slot with drive enable low, never on write or deselect
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_lane_oe <= 1'b0;
    end else begin
      o_lane_oe <= rd_pend && !oe_n_s && awake
                   && !(|mem_we)
                   && !(start && !sel);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  a_strobe_priority: assert property (
    (awake && p_strobe && !i_ctrl.controller_addr_strobe_n_n && sel) |=> (cur_addr == $past(i_addr)) && p_first
  ) else $error("processor strobe did not take priority");

  a_ctrl_strobe_load: assert property (
    (awake && c_strobe && sel) |=> (burst_cnt == `SBSA_BURST_ZERO)
      && (start_bits == $past(i_addr[`SBSA_BURST_W-1:0])) && (cur_addr == $past(i_addr))
  ) else $error("controller strobe did not load address");

  a_cs1_ignores_p: assert property (
    (awake && st == sbsa_pkg::SBSA_ACTIVE && !i_ctrl.processor_addr_strobe_n_n && i_ctrl.cs1_n
      && i_ctrl.controller_addr_strobe_n_n && i_ctrl.adv_n) |=> $stable(cur_addr) && st == sbsa_pkg::SBSA_ACTIVE
  ) else $error("processor strobe acted with select one high");

  a_burst_step: assert property (
    adv_step |=> burst_cnt == ($past(burst_cnt) + `SBSA_BURST_ONE)
  ) else $error("advance did not step the burst counter");

  a_burst_order: assert property (
    (st == sbsa_pkg::SBSA_ACTIVE)
      |-> cur_addr[`SBSA_BURST_W-1:0] == burst_bits(start_bits, burst_cnt, strap_s)
  ) else $error("burst address out of order");

  a_burst_hold: assert property (
    (awake && cont && i_ctrl.adv_n) |=> $stable(burst_cnt) && $stable(cur_addr)
  ) else $error("burst address moved without advance");

  a_read_pipe: assert property (
    rd_pend |=> {o_parity_lane, o_data_lane} == $past(mem_rdata)
  ) else $error("read data not from previous address");

  a_drive_gate: assert property (
    o_lane_oe |-> $past(rd_pend) && !$past(oe_n_s)
  ) else $error("lanes driven without read or drive enable");

  a_first_undriven: assert property (
    (st == sbsa_pkg::SBSA_IDLE && awake && start && sel) |=> !o_lane_oe
  ) else $error("first access cycle after deselect was driven");

  a_deselect_undrive: assert property (
    (awake && start && !sel) |=> !o_lane_oe
  ) else $error("deselect did not undrive the lanes");

  a_write_undrive: assert property (
    (|mem_we) |=> !o_lane_oe
  ) else $error("lanes driven during a write");

  a_global_write: assert property (
    (awake && cont && !i_ctrl.gw_n) |-> (mem_we == '1) && !rd_go
  ) else $error("global write did not hit every lane");

  a_byte_write: assert property (
    (awake && cont && i_ctrl.gw_n && !i_ctrl.bwe_n) |-> mem_we == ~i_lane_write_select_n
  ) else $error("byte write lanes wrong");

  a_sleep_quiet: assert property (
    (st == sbsa_pkg::SBSA_SLEEP) |-> (mem_we == '0) && !rd_go ##1 !o_lane_oe
  ) else $error("activity while asleep");

  a_back_to_back: assert property (
    (rd_go && !oe_n_s && awake) ##1 (rd_go && !oe_n_s && awake && !start) |=> o_lane_oe
  ) else $error("consecutive reads not driven");

endmodule
`default_nettype wire

// File: tb/sbsa_bus_model.sv
/*
 * controller side of the shared data and parity lanes: resolves the
 * wire from both parties' drive and keeps the controller's drive rules.
 * assumes: the bench supplies the controller word and its wish to drive.
 */
`timescale 1ns/1ps
`default_nettype none

module sbsa_bus_model (
  input  wire logic        i_core_clk,
  input  wire logic        i_dev_oe,
  input  wire logic        i_drive_enable_n,
  input  wire logic        i_ctl_drive,
  input  wire logic [35:0] i_dev_word,
  input  wire logic [35:0] i_ctl_word,
  output logic      [35:0] o_bus
);
  logic        ctl_on;
  logic [35:0] last = 36'h0;

  // controller drives only while the device output enable is off
  assign ctl_on = i_ctl_drive & i_drive_enable_n;

  // released lanes show the inverse of the last level, never a kind value
  always_comb begin
    if (i_dev_oe) begin
      o_bus = i_dev_word;
    end else if (ctl_on) begin
      o_bus = i_ctl_word;
    end else begin
      o_bus = ~last;
    end
  end

  // remember the last driven level
  always_ff @(posedge i_core_clk) begin
    if (i_dev_oe | ctl_on) begin
      last <= o_bus;
    end
  end
endmodule

`default_nettype wire

// File: tb/test_sync_burst_sram_access.sv
/*
 * self-checking bench of the burst sram access block.
 * assumes: inputs change at the falling edge; lanes resolved by the bus model.
 */
`timescale 1ns/1ps
`default_nettype none

module test_sync_burst_sram_access;
  localparam logic [7:0] K_IDLE = 8'h5F;
  localparam logic [7:0] K_RD   = 8'h57;
  localparam logic [7:0] K_WR   = 8'h55;
  localparam logic [7:0] K_BW   = 8'h56;
  localparam logic [7:0] K_PRD  = 8'h4F;
  localparam logic [7:0] K_ADV  = 8'h5B;
  localparam logic [7:0] K_BOTH = 8'h45;
  localparam logic [7:0] K_PX   = 8'hCF;
  localparam logic [7:0] K_DSL  = 8'h17;
  localparam logic [7:0] K_DS3  = 8'h77;
  localparam logic [7:0] K_CBW  = 8'h5E;

  logic                 clk;
  logic                 rst_n;
  logic [5:0]           addr;
  sbsa_pkg::sbsa_ctrl_t ctrl;
  logic [3:0]           sel_n;
  logic                 de_n;
  logic                 slp;
  logic                 strap;
  logic                 ctl_drv;
  logic [35:0]          ctl_word;
  logic [35:0]          bus;
  logic [31:0]          odata;
  logic [3:0]           opar;
  logic                 oe;
  logic                 asleep;
  int                   error_cnt;
  int                   tests_run;

  sbsa_top #(.ADDR_W(6), .LANES(4)) dut_u (
    .i_core_clk            (clk),
    .i_rst_n               (rst_n),
    .i_addr                (addr),
    .i_ctrl                (ctrl),
    .i_lane_write_select_n (sel_n),
    .i_drive_enable_n      (de_n),
    .i_sleep_request       (slp),
    .i_burst_order_strap   (strap),
    .i_data_lane           (bus[31:0]),
    .i_parity_lane         (bus[35:32]),
    .o_data_lane           (odata),
    .o_parity_lane         (opar),
    .o_lane_oe             (oe),
    .o_asleep              (asleep)
  );

  sbsa_bus_model bus_u (
    .i_core_clk       (clk),
    .i_dev_oe         (oe),
    .i_drive_enable_n (de_n),
    .i_ctl_drive      (ctl_drv),
    .i_dev_word       ({opar, odata}),
    .i_ctl_word       (ctl_word),
    .o_bus            (bus)
  );

  ////////////////////////////////////////////////////////////////////
  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    #(4000 * 4);
    error_cnt++;
    give_verdict();
  end

  ////////////////////////////////////////////////////////////////////
  // shared helpers
  function automatic logic [35:0] pat(input logic [5:0] a);
    return {a[3:0], 32'h9C3A5E71 ^ {4{2'h0, a}}};
  endfunction

  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one bus cycle: drive at the falling edge, return at the next one
  task automatic cyc(input logic [7:0] c, input logic [5:0] a);
    ctrl = sbsa_pkg::sbsa_ctrl_t'(c);
    addr = a;
    @(negedge clk);
  endtask

  // lanes must be driven with the given word
  task automatic rdc(input logic [35:0] w);
    chk({35'h0, oe}, 36'h1);
    chk(bus, w);
  endtask

  // hand the lanes to the controller or back to the device
  task automatic bus_own(input logic mine);
    de_n = mine;
    ctl_drv = mine;
    repeat (3) cyc(K_IDLE, 6'h00);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic s_write();
    bus_own(1'b1);
    for (int a = 0; a < 8; a++) begin
      ctl_word = pat(6'(a));
      cyc(K_WR, 6'(a));
      chk({35'h0, oe}, 36'h0);
    end
    cyc(K_DSL, 6'h00);
    bus_own(1'b0);
  endtask

  task automatic s_reads();
    cyc(K_RD, 6'h00);
    chk({35'h0, oe}, 36'h0);
    for (int a = 1; a < 8; a++) begin
      cyc(K_RD, 6'(a));
      rdc(pat(6'(a - 1)));
    end
    cyc(K_IDLE, 6'h00);
    rdc(pat(6'h07));
    cyc(K_DSL, 6'h00);
    chk({35'h0, oe}, 36'h0);
  endtask

  task automatic s_burst(input logic st, input logic [1:0] s);
    logic [1:0] n;
    strap = st;
    repeat (3) cyc(K_IDLE, 6'h00);
    cyc(K_RD, {4'h1, s});
    for (int k = 1; k < 7; k++) begin
      n = (k < 5) ? 2'(k - 1) : 2'(k - 2);
      cyc((k == 4 || k == 6) ? K_IDLE : K_ADV, 6'h00);
      rdc(pat({4'h1, st ? (s ^ n) : (s + n)}));
    end
    cyc(K_DSL, 6'h00);
  endtask

  task automatic s_pstrobe();
    cyc(K_PRD, 6'h03);
    cyc(K_PX, 6'h06);
    rdc(pat(6'h03));
    cyc(K_BOTH, 6'h05);
    rdc(pat(6'h03));
    repeat (2) begin
      cyc(K_IDLE, 6'h00);
      rdc(pat(6'h05));
    end
    cyc(K_DS3, 6'h00);
    chk({35'h0, oe}, 36'h0);
  endtask

  task automatic s_bytes();
    bus_own(1'b1);
    sel_n = 4'hA;
    ctl_word = 36'hF_FFFF_FFFF;
    cyc(K_BW, 6'h02);
    sel_n = 4'hE;
    ctl_word = 36'h5_A5A5_0F0F;
    cyc(K_WR, 6'h01);
    sel_n = 4'hF;
    cyc(K_DSL, 6'h00);
    bus_own(1'b0);
    cyc(K_RD, 6'h02);
    cyc(K_RD, 6'h01);
    rdc(pat(6'h02) | 36'h5_00FF_00FF);
    cyc(K_IDLE, 6'h00);
    rdc(36'h5_A5A5_0F0F);
    cyc(K_DSL, 6'h00);
  endtask

  // processor strobe opens the access, the next edge writes lane three only
  task automatic s_pwrite();
    bus_own(1'b1);
    sel_n = 4'h7;
    ctl_word = 36'hF_C300_0000;
    cyc(K_PRD, 6'h03);
    cyc(K_CBW, 6'h00);
    chk({35'h0, oe}, 36'h0);
    sel_n = 4'hF;
    cyc(K_DSL, 6'h00);
    bus_own(1'b0);
    cyc(K_RD, 6'h03);
    cyc(K_IDLE, 6'h00);
    rdc((pat(6'h03) & 36'h7_00FF_FFFF) | 36'h8_C300_0000);
    cyc(K_DSL, 6'h00);
  endtask

  task automatic s_drive_off();
    de_n = 1'b1;
    repeat (3) cyc(K_IDLE, 6'h00);
    cyc(K_RD, 6'h00);
    cyc(K_IDLE, 6'h00);
    chk({35'h0, oe}, 36'h0);
    cyc(K_DSL, 6'h00);
    de_n = 1'b0;
    repeat (3) cyc(K_IDLE, 6'h00);
  endtask

  task automatic s_sleep();
    slp = 1'b1;
    repeat (4) cyc(K_IDLE, 6'h00);
    chk({35'h0, asleep}, 36'h1);
    cyc(K_RD, 6'h04);
    cyc(K_IDLE, 6'h00);
    chk({35'h0, oe}, 36'h0);
    cyc(K_DSL, 6'h00);
    slp = 1'b0;
    repeat (4) cyc(K_IDLE, 6'h00);
    chk({35'h0, asleep}, 36'h0);
    cyc(K_RD, 6'h04);
    cyc(K_IDLE, 6'h00);
    rdc(pat(6'h04));
    cyc(K_DSL, 6'h00);
  endtask

  ////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    error_cnt = 0;
    tests_run = 0;
    rst_n = 1'b0;
    addr = 6'h00;
    ctrl = sbsa_pkg::sbsa_ctrl_t'(K_DSL);
    sel_n = 4'hF;
    de_n = 1'b0;
    slp = 1'b0;
    strap = 1'b0;
    ctl_drv = 1'b0;
    ctl_word = 36'h0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    chk({opar, odata}, 36'h0);
    chk({34'h0, oe, asleep}, 36'h0);
    repeat (3) cyc(K_IDLE, 6'h00);
    s_write();
    s_reads();
    s_burst(1'b0, 2'h2);
    s_burst(1'b1, 2'h1);
    s_pstrobe();
    s_bytes();
    s_pwrite();
    s_drive_off();
    s_sleep();
    give_verdict();
  end
endmodule

`default_nettype wire
